// [logic/pmcrb_command_bank.sv]
// Purpose: Command register bank of a strap-configured step-down module
// Assumes: A serial bus engine frames each command into one request cycle
// Notes:   Straps are caught once, in the first cycle after reset release
//
// Contract
// - Code 01h is a read/write byte holding on/off control settings.
// - Code 02h read/write byte selects enable pin use; default 16h.
// - Code 21h word holds output voltage setpoint from coarse/fine straps.
// - Code 24h word holds output voltage ceiling, default 110% of strap.
// - Code 33h word holds switching frequency, linear-11, from strap.
// - Code 37h word holds phase offset, default from strapped address.
// - Code 40h word holds output overvoltage limit, default 1.15x strap.
// - Code 44h word holds output undervoltage limit, default 0.85x strap.
// - Code 46h word holds overcurrent limit, reset E3C0h (60 A).
// - Code 4Bh word holds undercurrent limit, reset E440h (-60 A).
// - Code 4Fh word holds overtemperature limit, reset EB98h.
// - Code 53h word holds undertemperature limit, reset E530h.
// - Code 55h word holds input overvoltage limit, reset D3A0h.
// - Code 59h word holds input undervoltage limit from strap.
// - Code 5Eh word holds power-good level, default 0.9x strap.
// - Code 60h word holds turn-on wait, default from strap.
// - Code 61h word holds ramp-up duration, default from strap.
// - Code 64h word holds turn-off wait, default from strap.
// - Code 65h word holds ramp-down duration, default from strap.
// - Linear-11: 5-bit signed exponent high, 11-bit signed mantissa low.
// - Unsigned linear-16: 16-bit mantissa, fixed exponent minus thirteen.
`timescale 1ns/100ps

module pmcrb_command_bank
(
    input  wire logic                  clock,
    input  wire logic                  reset,
    input  wire pmcrb_pkg::pmcrb_strap_t straps,
    input  wire pmcrb_pkg::pmcrb_cmd_t cmdIn,
    output logic                       cmdReady,
    output logic                       rspValid,
    output logic                       rspError,
    output logic [15:0]                rspData,
    output logic                       faultClearPulse,
    output pmcrb_pkg::pmcrb_regs_t     regsOut,
    output logic [4:0]                 rateExponent,
    output logic [10:0]                rateMantissa
);
    import pmcrb_pkg::*;

    // ------------------------------------------------------------
    // Strap derived defaults
    // ------------------------------------------------------------
    logic [15:0] strapVout;
    logic [23:0] strapVoutWide;
    logic [15:0] strapCeiling;
    logic [15:0] strapOvervolt;
    logic [15:0] strapUndervolt;
    logic [15:0] strapGood;
    logic [15:0] defaults [REG_COUNT];

    assign strapVout = 16'(VOUT_BASE_CODE
                     + 16'(straps.coarseVoltage) * VOUT_COARSE_STEP
                     + 16'(straps.fineVoltage) * VOUT_FINE_STEP);
    assign strapVoutWide = {8'h00, strapVout};

    function automatic logic [15:0] scalePct(input logic [23:0] v,
                                             input logic [7:0]  pct);
        logic [31:0] prod;
        prod = 32'(v) * 32'(pct);
        scalePct = 16'(prod / 32'(PCT_DIVISOR));
    endfunction

    assign strapCeiling   = scalePct(strapVoutWide, PCT_CEILING);
    assign strapOvervolt  = scalePct(strapVoutWide, PCT_OVERVOLT);
    assign strapUndervolt = scalePct(strapVoutWide, PCT_UNDERVOLT);
    assign strapGood      = scalePct(strapVoutWide, PCT_GOOD);

    assign defaults[IDX_RUN]   = RUN_CONTROL_RESET;
    assign defaults[IDX_SRC]   = TURN_ON_SRC_RESET;
    assign defaults[IDX_VSET]  = strapVout;
    assign defaults[IDX_VMAX]  = strapCeiling;
    assign defaults[IDX_FSW]   = straps.switchingRate;
    assign defaults[IDX_PHASE] = {12'h000,
                                  straps.busAddress[3:0]};
    assign defaults[IDX_OOV]   = strapOvervolt;
    assign defaults[IDX_OUV]   = strapUndervolt;
    assign defaults[IDX_OC]    = OC_LIMIT_RESET;
    assign defaults[IDX_UC]    = UC_LIMIT_RESET;
    assign defaults[IDX_HOT]   = HOT_LIMIT_RESET;
    assign defaults[IDX_COLD]  = COLD_LIMIT_RESET;
    assign defaults[IDX_IOV]   = IN_OV_RESET;
    assign defaults[IDX_IUV]   = straps.inputUndervolt;
    assign defaults[IDX_GOOD]  = strapGood;
    assign defaults[IDX_TONW]  = straps.turnOnWait;
    assign defaults[IDX_TONR]  = straps.rampUpTime;
    assign defaults[IDX_TOFW]  = straps.turnOffWait;
    assign defaults[IDX_TOFF]  = straps.rampDownTime;

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    logic [7:0] codes [REG_COUNT];
    logic [REG_COUNT-1:0] hit;
    logic [4:0]  hitIndex;
    logic        anyHit;
    logic        isClear;
    logic        isByteReg;
    logic        isWrite;
    logic        isRead;
    logic        isWord;
    logic        sizeOk;
    logic        cmdTaken;
    logic        cmdGood;
    logic        doWrite;
    logic        doClear;

    assign codes[IDX_RUN]   = CMD_RUN_CONTROL;
    assign codes[IDX_SRC]   = CMD_TURN_ON_SOURCE;
    assign codes[IDX_VSET]  = CMD_VOUT_SETPOINT;
    assign codes[IDX_VMAX]  = CMD_VOUT_CEILING;
    assign codes[IDX_FSW]   = CMD_SWITCHING_RATE;
    assign codes[IDX_PHASE] = CMD_PHASE_OFFSET;
    assign codes[IDX_OOV]   = CMD_OUT_OV_LIMIT;
    assign codes[IDX_OUV]   = CMD_OUT_UV_LIMIT;
    assign codes[IDX_OC]    = CMD_OC_LIMIT;
    assign codes[IDX_UC]    = CMD_UC_LIMIT;
    assign codes[IDX_HOT]   = CMD_HOT_LIMIT;
    assign codes[IDX_COLD]  = CMD_COLD_LIMIT;
    assign codes[IDX_IOV]   = CMD_IN_OV_LIMIT;
    assign codes[IDX_IUV]   = CMD_IN_UV_LIMIT;
    assign codes[IDX_GOOD]  = CMD_GOOD_THRESHOLD;
    assign codes[IDX_TONW]  = CMD_TURN_ON_WAIT;
    assign codes[IDX_TONR]  = CMD_RAMP_UP_TIME;
    assign codes[IDX_TOFW]  = CMD_TURN_OFF_WAIT;
    assign codes[IDX_TOFF]  = CMD_RAMP_DOWN_TIME;

    genvar gi;
    generate
        for (gi = 0; gi < REG_COUNT; gi++)
        begin : g_hit
            assign hit[gi] = (cmdIn.code == codes[gi]);
        end
    endgenerate

    always_comb
    begin
        hitIndex = 5'h00;
        for (int i = 0; i < REG_COUNT; i++)
        begin
            if (hit[i])
            begin
                hitIndex = 5'(i);
            end
        end
    end

    assign anyHit    = |hit;
    assign isClear   = (cmdIn.code == CMD_FAULT_FLAG_CLEAR);
    assign isByteReg = (hitIndex < 5'(BYTE_REGS));
    assign isWrite   = (cmdIn.kind == XFER_WRITE_BYTE)
                     | (cmdIn.kind == XFER_WRITE_WORD);
    assign isRead    = (cmdIn.kind == XFER_READ_BYTE)
                     | (cmdIn.kind == XFER_READ_WORD);
    assign isWord    = (cmdIn.kind == XFER_WRITE_WORD)
                     | (cmdIn.kind == XFER_READ_WORD);
    assign sizeOk    = (isWrite | isRead) & (isWord != isByteReg);

    // ------------------------------------------------------------
    // Load and ready sequencing
    // ------------------------------------------------------------
    pmcrb_state_t state_reg;
    pmcrb_state_t state_next;

    always_comb
    begin
        case (state_reg)
            ST_LOAD:  state_next = ST_READY;
            ST_READY: state_next = ST_READY;
            default:  state_next = ST_LOAD;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (reset)
            state_reg <= ST_LOAD;
        else
            state_reg <= state_next;
    end

    assign cmdReady = (state_reg == ST_READY);
    assign cmdTaken = cmdIn.valid & cmdReady;
    assign doClear  = cmdTaken & isClear
                    & (cmdIn.kind == XFER_SEND_BYTE);
    assign cmdGood  = doClear | (anyHit & sizeOk);
    assign doWrite  = cmdTaken & anyHit & sizeOk & isWrite;

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [15:0] store_reg [REG_COUNT];

    generate
        for (gi = 0; gi < REG_COUNT; gi++)
        begin : g_store
            logic [15:0] wrValue;
            assign wrValue = (gi < BYTE_REGS)
                           ? {8'h00, cmdIn.data[7:0]} : cmdIn.data;
            always_ff @(posedge clock)
            begin
                if (reset)
                    store_reg[gi] <= 16'h0000;
                else if (state_reg == ST_LOAD)
                    store_reg[gi] <= defaults[gi];
                else if (doWrite && hit[gi])
                    store_reg[gi] <= wrValue;
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Answers and outputs
    // ------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            rspValid        <= 1'b0;
            rspError        <= 1'b0;
            rspData         <= 16'h0000;
            faultClearPulse <= 1'b0;
        end
        else
        begin
            rspValid        <= cmdTaken;
            rspError        <= cmdTaken & ~cmdGood;
            faultClearPulse <= doClear;
            if (cmdTaken && cmdGood && isRead)
                rspData <= store_reg[hitIndex];
            else if (cmdTaken)
                rspData <= 16'h0000;
        end
    end

    assign regsOut.runControl            = store_reg[IDX_RUN][7:0];
    assign regsOut.turnOnSourceConfig    = store_reg[IDX_SRC][7:0];
    assign regsOut.outputVoltageSetpoint = store_reg[IDX_VSET];
    assign regsOut.outputVoltageCeiling  = store_reg[IDX_VMAX];
    assign regsOut.switchingRate         = store_reg[IDX_FSW];
    assign regsOut.phaseOffset           = store_reg[IDX_PHASE];
    assign regsOut.outputOvervoltLimit   = store_reg[IDX_OOV];
    assign regsOut.outputUndervoltLimit  = store_reg[IDX_OUV];
    assign regsOut.overcurrentLimit      = store_reg[IDX_OC];
    assign regsOut.undercurrentLimit     = store_reg[IDX_UC];
    assign regsOut.hotLimit              = store_reg[IDX_HOT];
    assign regsOut.coldLimit             = store_reg[IDX_COLD];
    assign regsOut.inputOvervoltLimit    = store_reg[IDX_IOV];
    assign regsOut.inputUndervoltLimit   = store_reg[IDX_IUV];
    assign regsOut.goodOutputThreshold   = store_reg[IDX_GOOD];
    assign regsOut.turnOnWait            = store_reg[IDX_TONW];
    assign regsOut.rampUpTime            = store_reg[IDX_TONR];
    assign regsOut.turnOffWait           = store_reg[IDX_TOFW];
    assign regsOut.rampDownTime          = store_reg[IDX_TOFF];

    // Switching rate split into its linear-11 fields
    assign rateExponent = store_reg[IDX_FSW][L11_EXP_MSB:L11_EXP_LSB];
    assign rateMantissa = store_reg[IDX_FSW][L11_MANT_MSB:0];

endmodule

// [shared/pmcrb_pkg.sv]
// Purpose: Constants and types for the power module command register bank
// Assumes: Command codes arrive already framed by the serial bus engine
// Notes:   Linear-11 and unsigned linear-16 words are stored as raw bits
package pmcrb_pkg;

    // ------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_RUN_CONTROL      = 8'h01;
    localparam logic [7:0] CMD_TURN_ON_SOURCE   = 8'h02;
    localparam logic [7:0] CMD_FAULT_FLAG_CLEAR = 8'h03;
    localparam logic [7:0] CMD_VOUT_SETPOINT    = 8'h21;
    localparam logic [7:0] CMD_VOUT_CEILING     = 8'h24;
    localparam logic [7:0] CMD_SWITCHING_RATE   = 8'h33;
    localparam logic [7:0] CMD_PHASE_OFFSET     = 8'h37;
    localparam logic [7:0] CMD_OUT_OV_LIMIT     = 8'h40;
    localparam logic [7:0] CMD_OUT_UV_LIMIT     = 8'h44;
    localparam logic [7:0] CMD_OC_LIMIT         = 8'h46;
    localparam logic [7:0] CMD_UC_LIMIT         = 8'h4b;
    localparam logic [7:0] CMD_HOT_LIMIT        = 8'h4f;
    localparam logic [7:0] CMD_COLD_LIMIT       = 8'h53;
    localparam logic [7:0] CMD_IN_OV_LIMIT      = 8'h55;
    localparam logic [7:0] CMD_IN_UV_LIMIT      = 8'h59;
    localparam logic [7:0] CMD_GOOD_THRESHOLD   = 8'h5e;
    localparam logic [7:0] CMD_TURN_ON_WAIT     = 8'h60;
    localparam logic [7:0] CMD_RAMP_UP_TIME     = 8'h61;
    localparam logic [7:0] CMD_TURN_OFF_WAIT    = 8'h64;
    localparam logic [7:0] CMD_RAMP_DOWN_TIME   = 8'h65;

    // ------------------------------------------------------------
    // Storage indices
    // ------------------------------------------------------------
    localparam int REG_COUNT = 19;
    localparam int IDX_RUN   = 0;
    localparam int IDX_SRC   = 1;
    localparam int IDX_VSET  = 2;
    localparam int IDX_VMAX  = 3;
    localparam int IDX_FSW   = 4;
    localparam int IDX_PHASE = 5;
    localparam int IDX_OOV   = 6;
    localparam int IDX_OUV   = 7;
    localparam int IDX_OC    = 8;
    localparam int IDX_UC    = 9;
    localparam int IDX_HOT   = 10;
    localparam int IDX_COLD  = 11;
    localparam int IDX_IOV   = 12;
    localparam int IDX_IUV   = 13;
    localparam int IDX_GOOD  = 14;
    localparam int IDX_TONW  = 15;
    localparam int IDX_TONR  = 16;
    localparam int IDX_TOFW  = 17;
    localparam int IDX_TOFF  = 18;
    localparam int BYTE_REGS = 2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RUN_CONTROL_RESET = 16'h0000;
    localparam logic [15:0] TURN_ON_SRC_RESET = 16'h0016;
    localparam logic [15:0] OC_LIMIT_RESET    = 16'he3c0;
    localparam logic [15:0] UC_LIMIT_RESET    = 16'he440;
    localparam logic [15:0] HOT_LIMIT_RESET   = 16'heb98;
    localparam logic [15:0] COLD_LIMIT_RESET  = 16'he530;
    localparam logic [15:0] IN_OV_RESET       = 16'hd3a0;

    // ------------------------------------------------------------
    // Strap to output voltage, unsigned linear-16 (value / 8192)
    // ------------------------------------------------------------
    localparam logic [15:0] VOUT_BASE_CODE   = 16'h1333;
    localparam logic [15:0] VOUT_COARSE_STEP = 16'h0666;
    localparam logic [15:0] VOUT_FINE_STEP   = 16'h0052;
    localparam logic [23:0] PCT_DIVISOR      = 24'h00_0064;
    localparam logic [7:0]  PCT_CEILING      = 8'h6e;
    localparam logic [7:0]  PCT_OVERVOLT     = 8'h73;
    localparam logic [7:0]  PCT_UNDERVOLT    = 8'h55;
    localparam logic [7:0]  PCT_GOOD         = 8'h5a;

    // ------------------------------------------------------------
    // Linear-11 fields
    // ------------------------------------------------------------
    localparam int L11_EXP_MSB  = 15;
    localparam int L11_EXP_LSB  = 11;
    localparam int L11_MANT_MSB = 10;

    typedef enum logic [2:0] {
        XFER_SEND_BYTE,
        XFER_WRITE_BYTE,
        XFER_WRITE_WORD,
        XFER_READ_BYTE,
        XFER_READ_WORD
    } pmcrb_xfer_t;

    typedef struct packed {
        logic [3:0]  coarseVoltage;
        logic [3:0]  fineVoltage;
        logic [15:0] switchingRate;
        logic [15:0] inputUndervolt;
        logic [15:0] turnOnWait;
        logic [15:0] rampUpTime;
        logic [15:0] turnOffWait;
        logic [15:0] rampDownTime;
        logic [6:0]  busAddress;
    } pmcrb_strap_t;

    typedef struct packed {
        logic        valid;
        pmcrb_xfer_t kind;
        logic [7:0]  code;
        logic [15:0] data;
    } pmcrb_cmd_t;

    typedef struct packed {
        logic [7:0]  runControl;
        logic [7:0]  turnOnSourceConfig;
        logic [15:0] outputVoltageSetpoint;
        logic [15:0] outputVoltageCeiling;
        logic [15:0] switchingRate;
        logic [15:0] phaseOffset;
        logic [15:0] outputOvervoltLimit;
        logic [15:0] outputUndervoltLimit;
        logic [15:0] overcurrentLimit;
        logic [15:0] undercurrentLimit;
        logic [15:0] hotLimit;
        logic [15:0] coldLimit;
        logic [15:0] inputOvervoltLimit;
        logic [15:0] inputUndervoltLimit;
        logic [15:0] goodOutputThreshold;
        logic [15:0] turnOnWait;
        logic [15:0] rampUpTime;
        logic [15:0] turnOffWait;
        logic [15:0] rampDownTime;
    } pmcrb_regs_t;

    typedef enum logic {
        ST_LOAD,
        ST_READY
    } pmcrb_state_t;

endpackage

// [sim/pmcrb_command_bank_asserts.sv]
// Purpose: Port checks for the command register bank
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to every bank instance
`timescale 1ns/100ps
module pmcrb_command_bank_asserts
(
    input wire logic                    clock,
    input wire logic                    reset,
    input wire pmcrb_pkg::pmcrb_strap_t straps,
    input wire pmcrb_pkg::pmcrb_cmd_t   cmdIn,
    input wire logic                    cmdReady,
    input wire logic                    rspValid,
    input wire logic                    rspError,
    input wire logic [15:0]             rspData,
    input wire logic                    faultClearPulse,
    input wire pmcrb_pkg::pmcrb_regs_t  regsOut,
    input wire logic [4:0]              rateExponent,
    input wire logic [10:0]             rateMantissa
);
    import pmcrb_pkg::*;
    wire taken = cmdIn.valid && cmdReady;
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    property p_answer;
        taken |=> rspValid;
    endproperty
    a_answer: assert property (p_answer) else $error("no answer");
    property p_no_stray;
        !taken |=> !rspValid && !faultClearPulse;
    endproperty
    a_no_stray: assert property (p_no_stray) else $error("stray");
    property p_clear;
        taken && cmdIn.kind == XFER_SEND_BYTE && cmdIn.code == 8'h03
            |=> faultClearPulse && !rspError;
    endproperty
    a_clear: assert property (p_clear) else $error("no clear");
    property p_clear_cause;
        faultClearPulse |-> $past(taken) && $past(cmdIn.code) == 8'h03;
    endproperty
    a_clear_cause: assert property (p_clear_cause) else $error("clear");
    property p_load;
        $fell(reset) |-> !cmdReady ##1 cmdReady;
    endproperty
    a_load: assert property (p_load) else $error("ready timing");
    property p_defaults;
        $rose(cmdReady) |-> regsOut.overcurrentLimit == 16'he3c0
            && regsOut.undercurrentLimit == 16'he440
            && regsOut.hotLimit == 16'heb98 && regsOut.coldLimit == 16'he530
            && regsOut.inputOvervoltLimit == 16'hd3a0
            && regsOut.turnOnSourceConfig == 8'h16;
    endproperty
    a_defaults: assert property (p_defaults) else $error("default");
    property p_oc_write;
        taken && cmdIn.kind == XFER_WRITE_WORD && cmdIn.code == 8'h46
            |=> regsOut.overcurrentLimit == $past(cmdIn.data);
    endproperty
    a_oc_write: assert property (p_oc_write) else $error("oc write");
    property p_rate;
        rateExponent == regsOut.switchingRate[15:11]
            && rateMantissa == regsOut.switchingRate[10:0];
    endproperty
    a_rate: assert property (p_rate) else $error("rate fields");
    property p_refuse;
        rspValid && rspError |-> rspData == 16'h0000 && $stable(regsOut);
    endproperty
    a_refuse: assert property (p_refuse) else $error("refusal");
endmodule

bind pmcrb_command_bank pmcrb_command_bank_asserts chkU
(
    .clock(clock), .reset(reset), .straps(straps), .cmdIn(cmdIn),
    .cmdReady(cmdReady), .rspValid(rspValid), .rspError(rspError),
    .rspData(rspData), .faultClearPulse(faultClearPulse),
    .regsOut(regsOut), .rateExponent(rateExponent),
    .rateMantissa(rateMantissa)
);

// [sim/pmcrb_host_model.sv]
// Purpose: Host side model that frames commands for the bank
// Assumes: Requests change on falling edges
// Notes:   Valid stays high so calls may follow back to back
`timescale 1ns/100ps
module pmcrb_host_model
(
    input  wire logic             clock,
    input  wire logic             rspValid,
    input  wire logic             rspError,
    input  wire logic [15:0]      rspData,
    input  wire logic             faultClearPulse,
    output pmcrb_pkg::pmcrb_cmd_t cmdOut
);
    import pmcrb_pkg::*;
    initial cmdOut = '0;
    // Called at a falling edge, returns at the next with the answer
    task automatic issue(input pmcrb_xfer_t k, input logic [7:0] c,
                         input logic [15:0] d, output logic [18:0] a);
        cmdOut <= {1'b1, k, c, (k == XFER_SEND_BYTE) ? 16'h0000 : d};
        @(negedge clock);
        a = {rspValid, rspError, faultClearPulse, rspData};
    endtask
    task automatic idle;
        cmdOut.valid <= 1'b0;
        @(negedge clock);
    endtask
endmodule

// [sim/pmcrb_command_bank_tb_top.sv]
// Purpose: Self-checking bench for the command register bank
// Assumes: Host model drives requests on falling edges
// Notes:   Reference contents are kept in plain arrays
`timescale 1ns/100ps
module pmcrb_command_bank_tb_top;
    import pmcrb_pkg::*;
    logic clock, reset, cmdReady, rspValid, rspError, faultClearPulse;
    logic [15:0] rspData;
    logic [4:0] rateExponent;
    logic [10:0] rateMantissa;
    pmcrb_strap_t straps;
    pmcrb_cmd_t cmdIn;
    pmcrb_regs_t regsOut;
    logic [31:0] lfsr;
    logic [18:0] ans;
    int n_errors, cmp_count, v;
    int wid [256];
    logic [15:0] mdl [256];
    logic [7:0] codes [20] = '{8'h01, 8'h02, 8'h03, 8'h21, 8'h24, 8'h33,
        8'h37, 8'h40, 8'h44, 8'h46, 8'h4b, 8'h4f, 8'h53, 8'h55, 8'h59,
        8'h5e, 8'h60, 8'h61, 8'h64, 8'h65};

    pmcrb_command_bank dut_u (.clock(clock), .reset(reset),
        .straps(straps), .cmdIn(cmdIn), .cmdReady(cmdReady),
        .rspValid(rspValid), .rspError(rspError), .rspData(rspData),
        .faultClearPulse(faultClearPulse), .regsOut(regsOut),
        .rateExponent(rateExponent), .rateMantissa(rateMantissa));
    pmcrb_host_model hostU (.clock(clock), .rspValid(rspValid),
        .rspError(rspError), .rspData(rspData),
        .faultClearPulse(faultClearPulse), .cmdOut(cmdIn));

    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    function automatic pmcrb_xfer_t kind_of(input int w, input logic wr);
        if (w == 1)
            return wr ? XFER_WRITE_BYTE : XFER_READ_BYTE;
        if (w == 2)
            return wr ? XFER_WRITE_WORD : XFER_READ_WORD;
        return XFER_SEND_BYTE;
    endfunction

    task automatic give_verdict;
        $display("errors %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input logic [18:0] g, input logic [18:0] e);
        cmp_count++;
        if (g !== e)
        begin
            n_errors++;
            $display("FAIL %0t got %h expected %h", $time, g, e);
        end
    endtask

    task automatic op(input pmcrb_xfer_t k, input logic [7:0] c,
                      input logic [15:0] d);
        logic ok, rd;
        logic [18:0] e, m;
        ok = (wid[c] == 1 && (k == XFER_WRITE_BYTE || k == XFER_READ_BYTE))
            || (wid[c] == 2 && (k == XFER_WRITE_WORD || k == XFER_READ_WORD))
            || (wid[c] == 3 && k == XFER_SEND_BYTE);
        rd = ok && (k == XFER_READ_BYTE || k == XFER_READ_WORD);
        e = {1'b1, !ok, ok && k == XFER_SEND_BYTE, rd ? mdl[c] : 16'h0000};
        m = (ok && !rd) ? 19'h7_0000 : 19'h7_ffff;
        hostU.issue(k, c, d, ans);
        check(ans & m, e & m);
        if (ok && k == XFER_WRITE_BYTE)
            mdl[c] = {8'h00, d[7:0]};
        if (ok && k == XFER_WRITE_WORD)
            mdl[c] = d;
    endtask

    task automatic sweep(input logic wr);
        foreach (codes[i])
        begin
            lfsr = lfsr_next(lfsr);
            op(kind_of(wid[codes[i]], wr), codes[i], lfsr[15:0]);
        end
    endtask

    task automatic load_model;
        foreach (codes[i])
            wid[codes[i]] = (i < 2) ? 1 : (i == 2) ? 3 : 2;
        v = (32'h1333 + straps.coarseVoltage * 32'h0666
            + straps.fineVoltage * 32'h0052) & 32'hffff;
        mdl[8'h01] = 16'h0000;
        mdl[8'h02] = 16'h0016;
        mdl[8'h21] = 16'(v);
        mdl[8'h24] = 16'(v * 110 / 100);
        mdl[8'h33] = straps.switchingRate;
        mdl[8'h37] = {12'h000, straps.busAddress[3:0]};
        mdl[8'h40] = 16'(v * 115 / 100);
        mdl[8'h44] = 16'(v * 85 / 100);
        mdl[8'h46] = 16'he3c0;
        mdl[8'h4b] = 16'he440;
        mdl[8'h4f] = 16'heb98;
        mdl[8'h53] = 16'he530;
        mdl[8'h55] = 16'hd3a0;
        mdl[8'h59] = straps.inputUndervolt;
        mdl[8'h5e] = 16'(v * 90 / 100);
        mdl[8'h60] = straps.turnOnWait;
        mdl[8'h61] = straps.rampUpTime;
        mdl[8'h64] = straps.turnOffWait;
        mdl[8'h65] = straps.rampDownTime;
    endtask

    task automatic do_reset;
        int k;
        lfsr = lfsr_next(lfsr);
        straps = pmcrb_strap_t'({lfsr, ~lfsr, lfsr, lfsr[14:0]});
        reset <= 1'b1;
        repeat (16) @(negedge clock);
        reset <= 1'b0;
        hostU.issue(XFER_WRITE_WORD, 8'h46, 16'h0bad, ans);
        check({18'h0, ans[18]}, 19'h0);
        hostU.issue(XFER_READ_WORD, 8'h4f, 16'h0000, ans);
        check(ans, {3'b100, HOT_LIMIT_RESET});
        hostU.idle();
        k = 0;
        while (cmdReady !== 1'b1 && k < 20)
        begin
            @(negedge clock);
            k++;
        end
        if (cmdReady !== 1'b1)
        begin
            n_errors++;
            give_verdict();
        end
        load_model();
    endtask

    initial
    begin
        repeat (100000) @(posedge clock);
        n_errors++;
        give_verdict();
    end

    initial
    begin
        n_errors = 0;
        cmp_count = 0;
        lfsr = 32'h0000_0bef;
        reset = 1'b1;
        straps = '0;
        @(negedge clock);
        do_reset();
        sweep(1'b0);
        sweep(1'b1);
        sweep(1'b0);
        check({3'h0, rateExponent, rateMantissa}, {3'h0, mdl[8'h33]});
        check({3'h0, regsOut.overcurrentLimit}, {3'h0, mdl[8'h46]});
        op(XFER_READ_WORD, 8'h00, 16'h0000);
        op(XFER_READ_WORD, 8'h7f, 16'h0000);
        op(XFER_READ_BYTE, 8'h46, 16'h0000);
        op(XFER_WRITE_WORD, 8'h01, 16'h5aa5);
        op(XFER_READ_BYTE, 8'h03, 16'h0000);
        op(XFER_WRITE_BYTE, 8'h03, 16'h0011);
        op(XFER_SEND_BYTE, 8'h21, 16'h0000);
        op(XFER_SEND_BYTE, 8'h03, 16'h0000);
        sweep(1'b0);
        hostU.idle();
        do_reset();
        sweep(1'b0);
        give_verdict();
    end
endmodule
